// *** core/adcf_top.v ***
// converter configuration register and result formatting with an
// avalon-mm slave; assumes the sequencer pulses done_i with its result
`timescale 1ns/1ps
`default_nettype none
`include "adcf_map.vh"

// Contract
// RQ1: left format: high holds result 9..2
// RQ2: left format: low 7..6 hold result 1..0
// RQ3: left format: low 5..0 reserved
// RQ4: right format: high 1..0 hold result 9..8
// RQ5: right format: high 7..2 reserved
// RQ6: right format: low holds result 7..0
// RQ7: format select is config bit 7
// RQ8: clock select bits 6..4, 011 rc
// RQ9: codes 001/8, 010/32, 100/4, 101/16
// RQ10: negative reference bit 2, clear means ground
// RQ11: positive reference 00 supply, 10 external pin
// RQ12: unimplemented bits read zero, ignore writes
// RQ13: config clears on reset; results keep
// RQ14: busy clears when conversion completes
// RQ15: both results written in one cycle
// RQ16: positive reference 11 selects fixed reference
module adcf_top (
   input wire core_clk_i,
   input wire rst_i,
   input wire [3:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   input wire start_i,
   input wire done_i,
   input wire [9:0] result_i,
   input wire rc_tick_i,
   output reg conv_tick_o,
   output reg busy_o,
   output reg neg_ref_vss_o,
   output reg [1:0] pos_ref_sel_o,
   output reg pos_ref_valid_o
);
   reg [7:0] cfg_r;
   reg [7:0] cfg_nxt;
   reg [7:0] res_high_r;
   reg [7:0] res_high_nxt;
   reg [7:0] res_low_r;
   reg [7:0] res_low_nxt;
   reg busy_r;
   reg busy_nxt;
   reg ack_r;
   reg ack_nxt;
   reg wait_nxt;
   reg [31:0] rdata_nxt;
   reg [7:0] rd_byte;
   reg [7:0] fmt_high;
   reg [7:0] fmt_low;
   reg conv_tick_nxt;
   reg neg_ref_vss_nxt;
   reg [1:0] pos_ref_sel_nxt;
   reg pos_ref_valid_nxt;
   wire div_tick;
   wire req;
   wire take;
   wire wr_lane0;
   wire wr_cfg;
   wire wr_high;
   wire wr_low;
   wire load_res;
   wire fmt_right;
   wire [2:0] clk_sel;
   wire [1:0] pref_code;

   // one comparator shape for both the read mux and the write strobes
   function hit;
      input [3:0] addr;
      input [3:0] ofs;
      begin
         hit = (addr == ofs);
      end
   endfunction

   // high result byte; reserved bits are loaded as zero
   function [7:0] place_high;
      input right;
      input [9:0] res;
      begin
         if (right) begin
            place_high = {6'h00, res[9:8]}; // [RQ4] [RQ5]
         end else begin
            place_high = res[9:2]; // [RQ1]
         end
      end
   endfunction

   function [7:0] place_low;
      input right;
      input [9:0] res;
      begin
         if (right) begin
            place_low = res[7:0]; // [RQ6]
         end else begin
            place_low = {res[1:0], 6'h00}; // [RQ2] [RQ3]
         end
      end
   endfunction

   // reserved code 01 is passed through but flagged as not valid
   function ref_code_ok;
      input [1:0] code;
      begin
         ref_code_ok = (code != `ADCF_PREF_RSVD);
      end
   endfunction

   // status byte: only the busy bit is live, the rest read zero
   function [7:0] status_byte;
      input busy;
      begin
         status_byte = 8'h00;
         status_byte[`ADCF_STAT_BUSY_BIT] = busy;
      end
   endfunction

   assign req = avs_read | avs_write;
   assign take = req & ~ack_r;
   assign wr_lane0 = avs_write & avs_byteenable[0] & ~ack_r;
   assign wr_cfg = wr_lane0 & hit(avs_address, `ADCF_OFS_CONFIG);
   assign wr_high = wr_lane0 & hit(avs_address, `ADCF_OFS_RES_HIGH);
   assign wr_low = wr_lane0 & hit(avs_address, `ADCF_OFS_RES_LOW);
   assign load_res = done_i & busy_r;
   assign fmt_right = cfg_r[`ADCF_CFG_FMT_BIT]; // [RQ7]
   assign clk_sel = cfg_r[`ADCF_CFG_CLK_HI:`ADCF_CFG_CLK_LO];
   assign pref_code = cfg_r[`ADCF_CFG_PREF_HI:`ADCF_CFG_PREF_LO];

   adcf_clkdiv u_div (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .sel_i(clk_sel),
      .rc_tick_i(rc_tick_i),
      .tick_o(div_tick)
   );

   // arrange the incoming result per the format bit at completion
   always @* begin
      fmt_high = place_high(fmt_right, result_i);
      fmt_low = place_low(fmt_right, result_i);
   end

   always @* begin
      if (hit(avs_address, `ADCF_OFS_CONFIG)) begin
         rd_byte = cfg_r & `ADCF_CFG_WMASK; // [RQ12]
      end else if (hit(avs_address, `ADCF_OFS_RES_HIGH)) begin
         rd_byte = res_high_r;
      end else if (hit(avs_address, `ADCF_OFS_RES_LOW)) begin
         rd_byte = res_low_r;
      end else if (hit(avs_address, `ADCF_OFS_STATUS)) begin
         rd_byte = status_byte(busy_r);
      end else begin
         rd_byte = 8'h00; // [RQ12]
      end
   end

   // one wait cycle per access; ack_r blocks a second take of the
   // same request while the master still holds it after the answer
   always @* begin
      ack_nxt = take;
      wait_nxt = ~take;
      rdata_nxt = {24'h00_0000, rd_byte};
   end

   always @(posedge core_clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= ack_nxt;
      end
   end

   always @(posedge core_clk_i) begin
      if (rst_i) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= wait_nxt;
      end
   end

   always @(posedge core_clk_i) begin
      if (rst_i) begin
         avs_readdata <= 32'h0000_0000;
      end else begin
         avs_readdata <= rdata_nxt;
      end
   end

   always @* begin
      cfg_nxt = cfg_r;
      if (wr_cfg) begin
         cfg_nxt = avs_writedata[7:0] & `ADCF_CFG_WMASK; // [RQ12]
      end
   end

   // config clears on every reset
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         cfg_r <= `ADCF_CFG_RESET; // [RQ13]
      end else begin
         cfg_r <= cfg_nxt;
      end
   end

   // completion beats a software write to the same register
   always @* begin
      res_high_nxt = res_high_r;
      res_low_nxt = res_low_r;
      if (load_res) begin
         res_high_nxt = fmt_high; // [RQ15]
         res_low_nxt = fmt_low; // [RQ15]
      end else begin
         if (wr_high) begin
            res_high_nxt = avs_writedata[7:0];
         end
         if (wr_low) begin
            res_low_nxt = avs_writedata[7:0];
         end
      end
   end

   // results take no reset so they keep their value across one
   always @(posedge core_clk_i) begin
      res_high_r <= res_high_nxt; // [RQ13]
      res_low_r <= res_low_nxt; // [RQ13]
   end

   // completion wins over a new start in the same cycle
   always @* begin
      busy_nxt = busy_r;
      if (done_i) begin
         busy_nxt = 1'b0; // [RQ14]
      end else if (start_i) begin
         busy_nxt = 1'b1;
      end
   end

   always @(posedge core_clk_i) begin
      if (rst_i) begin
         busy_r <= 1'b0;
      end else begin
         busy_r <= busy_nxt;
      end
   end

   always @* begin
      conv_tick_nxt = div_tick & busy_r;
      neg_ref_vss_nxt = ~cfg_r[`ADCF_CFG_NREF_BIT]; // [RQ10]
      pos_ref_sel_nxt = pref_code; // [RQ11] [RQ16]
      pos_ref_valid_nxt = ref_code_ok(pref_code); // [RQ11]
   end

   always @(posedge core_clk_i) begin
      if (rst_i) begin
         conv_tick_o <= 1'b0;
      end else begin
         conv_tick_o <= conv_tick_nxt;
      end
   end

   always @(posedge core_clk_i) begin
      if (rst_i) begin
         busy_o <= 1'b0;
      end else begin
         busy_o <= busy_r;
      end
   end

   always @(posedge core_clk_i) begin
      if (rst_i) begin
         neg_ref_vss_o <= 1'b1;
      end else begin
         neg_ref_vss_o <= neg_ref_vss_nxt;
      end
   end

   always @(posedge core_clk_i) begin
      if (rst_i) begin
         pos_ref_sel_o <= `ADCF_PREF_SUPPLY;
      end else begin
         pos_ref_sel_o <= pos_ref_sel_nxt;
      end
   end

   always @(posedge core_clk_i) begin
      if (rst_i) begin
         pos_ref_valid_o <= 1'b1;
      end else begin
         pos_ref_valid_o <= pos_ref_valid_nxt;
      end
   end
endmodule

`default_nettype wire

// *** core/adcf_map.vh ***
// register map, field positions and reset values of the converter
// configuration and result formatting block; definitions only
`ifndef ADCF_MAP_VH
`define ADCF_MAP_VH

`define ADCF_OFS_CONFIG 4'h0
`define ADCF_OFS_RES_HIGH 4'h4
`define ADCF_OFS_RES_LOW 4'h8
`define ADCF_OFS_STATUS 4'hc

`define ADCF_CFG_FMT_BIT 7
`define ADCF_CFG_CLK_HI 6
`define ADCF_CFG_CLK_LO 4
`define ADCF_CFG_NREF_BIT 2
`define ADCF_CFG_PREF_HI 1
`define ADCF_CFG_PREF_LO 0
`define ADCF_CFG_WMASK 8'hf7
`define ADCF_CFG_RESET 8'h00

`define ADCF_STAT_BUSY_BIT 1

`define ADCF_CLK_DIV2 3'h0
`define ADCF_CLK_DIV8 3'h1
`define ADCF_CLK_DIV32 3'h2
`define ADCF_CLK_RC 3'h3
`define ADCF_CLK_DIV4 3'h4
`define ADCF_CLK_DIV16 3'h5
`define ADCF_CLK_DIV64 3'h6

`define ADCF_PREF_SUPPLY 2'h0
`define ADCF_PREF_RSVD 2'h1
`define ADCF_PREF_EXT 2'h2
`define ADCF_PREF_FIXED 2'h3

`define ADCF_RESULT_WIDTH 10

`endif

// *** core/adcf_clkdiv.v ***
// conversion clock enable generator: one-cycle pulse every n core cycles
// assumes a single core clock; the rc source is external and only gated
`timescale 1ns/1ps
`default_nettype none
`include "adcf_map.vh"

module adcf_clkdiv (
   input wire core_clk_i,
   input wire rst_i,
   input wire [2:0] sel_i,
   input wire rc_tick_i,
   output reg tick_o
);
   reg [5:0] cnt_r;
   reg [5:0] cnt_nxt;
   reg [5:0] last;

   // divisor minus one for each clock select code
   function [5:0] div_last;
      input [2:0] code;
      begin
         case (code)
            `ADCF_CLK_DIV8: div_last = 6'h07; // [RQ9]
            `ADCF_CLK_DIV32: div_last = 6'h1f; // [RQ9]
            `ADCF_CLK_DIV4: div_last = 6'h03; // [RQ9]
            `ADCF_CLK_DIV16: div_last = 6'h0f; // [RQ9]
            `ADCF_CLK_DIV64: div_last = 6'h3f;
            default: div_last = 6'h01;
         endcase
      end
   endfunction

   always @* begin
      last = div_last(sel_i);
      cnt_nxt = (cnt_r >= last) ? 6'h00 : cnt_r + 6'h01;
   end

   always @(posedge core_clk_i) begin
      if (rst_i) begin
         cnt_r <= 6'h00;
         tick_o <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         if (sel_i == `ADCF_CLK_RC) begin
            tick_o <= rc_tick_i; // [RQ8]
         end else begin
            tick_o <= (cnt_r >= last);
         end
      end
   end
endmodule

`default_nettype wire

// *** tb/adcf_top_sva.sv ***
// checker for adcf_top: bus timing, busy flag, reference outputs
// sees only the top ports; bound below
`timescale 1ns/1ps
`default_nettype none
module adcf_top_sva (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic start_i,
   input wire logic done_i,
   input wire logic busy_o,
   input wire logic neg_ref_vss_o,
   input wire logic [1:0] pos_ref_sel_o,
   input wire logic pos_ref_valid_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   a_rd_upper_zero: assert property (
      !avs_waitrequest |-> avs_readdata[31:8] == 24'h0) else $error("rd");
   a_busy_clear: assert property (
      done_i |-> ##2 !busy_o) else $error("busy stuck");
   a_busy_set: assert property (
      start_i && !done_i |-> ##2 busy_o) else $error("busy late");
   a_wait_one: assert property (
      $rose(avs_read || avs_write) |=> !avs_waitrequest) else $error("wait");
   a_wait_pulse: assert property (
      !avs_waitrequest |=> avs_waitrequest) else $error("ack long");
   a_ref_valid: assert property (
      pos_ref_valid_o == (pos_ref_sel_o != 2'h1)) else $error("valid");
   // refs may only move right after a write lands
   a_ref_hold: assert property (
      !avs_write && !$past(avs_write) |-> $stable(pos_ref_sel_o)
      && $stable(neg_ref_vss_o)) else $error("ref moved");
   a_out_reset: assert property (
      $fell(rst_i) |-> neg_ref_vss_o && pos_ref_sel_o == 2'h0 && !busy_o)
      else $error("reset out");
   cover property (done_i && busy_o);
   cover property (avs_write && !avs_waitrequest);
   cover property (pos_ref_sel_o == 2'h3);
endmodule
bind adcf_top adcf_top_sva u_sva (.*);
`default_nettype wire

// *** tb/adcf_top_tb.sv ***
// bench for adcf_top: formats, clock codes, refs, reset
// drives the avalon port and sequencer pulses itself
`timescale 1ns/1ps
`default_nettype none
module adcf_top_tb;
   logic core_clk_i = 0, rst_i = 1, avs_read = 0, avs_write = 0;
   logic start_i = 0, done_i = 0, rc_tick_i = 0, avs_waitrequest;
   logic conv_tick_o, busy_o, neg_ref_vss_o, pos_ref_valid_o;
   logic [1:0] pos_ref_sel_o;
   logic [3:0] avs_address = 0;
   logic [9:0] result_i = 0;
   logic [31:0] avs_writedata = 0, avs_readdata, rd;
   logic [41:0] rows [5];
   int failures = 0, tests_run = 0, n, g;
   adcf_top u_dut (.*, .avs_byteenable(4'h1));
   initial forever #5 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) rc_tick_i <= !rc_tick_i;
   initial begin
      #60000;
      failures++;
      close_out;
   end
   task close_out;
      $display("errors %0d checks %0d", failures, tests_run);
      if (failures == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic [31:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // no fixed latency assumed: waitrequest low ends the wait, or a 20-cycle limit that counts as a failure
   task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      {avs_write, avs_read, avs_address} <= {w, !w, a};
      avs_writedata <= {24'h0, d};
      n = 0;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      rd = avs_readdata;
      {avs_write, avs_read} <= 2'b00;
      if (n == 20) chk(0, 1);
   endtask
   task tick(output int c);
      c = 0;
      do begin
         @(posedge core_clk_i);
         c++;
      end while (conv_tick_o !== 1'b1 && c < 99);
   endtask
   initial begin
      // config, result, tick gap, high, low; rc source toggles, gap 2
      rows = '{{8'h10, 10'h3a5, 8'd8, 8'he9, 8'h40},
               {8'h20, 10'h2c3, 8'd32, 8'hb0, 8'hc0},
               {8'hc0, 10'h3a5, 8'd4, 8'h03, 8'ha5},
               {8'hd0, 10'h1fe, 8'd16, 8'h01, 8'hfe},
               {8'hb0, 10'h2c3, 8'd2, 8'h02, 8'hc3}};
      repeat (12) @(posedge core_clk_i);
      rst_i <= 0;
      foreach (rows[i]) begin
         bus(1, 4'h0, rows[i][41:34]);
         start_i <= 1;
         tick(g);
         start_i <= 0;
         bus(0, 4'hc, 0);
         chk(rd, 32'h2);
         tick(g);
         tick(g);
         chk(g, rows[i][23:16]);
         {done_i, result_i} <= {1'b1, rows[i][33:24]};
         @(posedge core_clk_i);
         done_i <= 0;
         bus(0, 4'h4, 0);
         chk(rd, rows[i][15:8]);
         bus(0, 4'h8, 0);
         chk(rd, rows[i][7:0]);
         bus(0, 4'hc, 0);
         chk(rd, 0);
      end
      bus(1, 4'h0, 8'hff);
      bus(0, 4'h0, 0);
      chk(rd, 32'hf7);
      chk({neg_ref_vss_o, pos_ref_sel_o, pos_ref_valid_o}, 4'h7);
      bus(1, 4'h0, 8'h01);
      bus(0, 4'h2, 0);
      chk(rd, 0);
      chk({neg_ref_vss_o, pos_ref_sel_o, pos_ref_valid_o}, 4'ha);
      rst_i <= 1;
      repeat (2) @(posedge core_clk_i);
      rst_i <= 0;
      bus(0, 4'h0, 0);
      chk(rd, 0);
      bus(0, 4'h8, 0);
      chk(rd, 32'hc3);
      close_out;
   end
endmodule
`default_nettype wire
